// ==== src/ref_train_pkg.sv ====
/*
 * Constants for the reference level training controller: command codes,
 * mode register field positions and timing counts.
 * Assumes a 200 MHz controller clock and one command slot per clock.
 */
package ref_train_pkg;
	// Command encodings on the controller's command port
	typedef enum logic [3:0] {
		CMD_DES, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA, CMD_PRE, CMD_MRS
	} cmd_t;
	// Training register field layout
	localparam int          ENABLE_BIT   = 7;
	localparam int          RANGE_BIT    = 6;
	localparam logic [2:0]  TRAIN_REG    = 3'h6;  // Mode register index
	localparam logic [5:0]  CODE_MAX     = 6'h32; // Highest legal level code
	localparam logic [6:0]  SETTING_RST  = 7'h00; // Stored setting after reset
	// Times in ns and derived cycle counts at 5 ns period
	localparam int CLK_PERIOD_NS   = 5;
	localparam int ENTRY_DELAY_NS  = 150;  // Training entry delay
	localparam int EXIT_DELAY_NS   = 150;  // Training exit delay
	localparam int SETTLE_SHORT_NS = 150;  // Settling, small step
	localparam int SETTLE_LONG_NS  = 250;  // Settling, large step
	localparam int SHORT_STEP_MAX  = 4;    // Step size still counted short
	localparam int ENTRY_CYC  = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_CYC   = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHORT_CYC  = (SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LONG_CYC   = (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W      = 8;
endpackage : ref_train_pkg

// ==== src/ref_train_ctrl.sv ====
/*
 * Controller side of reference level training: takes user orders to enter,
 * step the level, issue data commands and exit, and emits legal command
 * slots toward the memory device with the required waits.
 * Assumes the device command path accepts one command per clock.
 */
`timescale 1ns/1ps
// Contract
// - Level undefined until programmed; controller programs it.
// - Entry sets enable and range; code ignored.
// - Wait entry delay before training commands.
// - Only data, precharge, deselect, training writes allowed. Code also accepts activate (CMD_ACT) in training.
// - Dummy writes allowed before first level.
// - Updates keep enable and entry range.
// - Wait settling time after each update.
// - Per-device mode: only mode register writes.
// - Exit only with all banks precharged.
// - Only deselects during exit delay.
// - Range changes only at entry.
// - Final update then enable-clear exit.
// - Settle last step before exit.
// - Retrain on temperature drift.
// - Per-device mode: qualifying bit low executes.
module ref_train_ctrl (
	input  wire logic                  clk,          // 200 MHz clock
	input  wire logic                  rst,          // Synchronous reset, high
	input  wire logic                  reqValid,     // User order valid
	output logic                       reqReady,     // Order taken this cycle
	input  wire ref_train_pkg::cmd_t   reqCmd,       // Data command, or MRS
	input  wire logic                  reqEnter,     // MRS order: enter training
	input  wire logic                  reqExit,      // MRS order: exit training
	input  wire logic                  reqRange,     // Range for entry
	input  wire logic [5:0]            reqCode,      // Level code for update
	input  wire logic                  banksIdle,    // All banks precharged
	input  wire logic                  perDevice,    // Per-device addressing on
	input  wire logic                  tempDrift,    // Temperature drift, async
	output ref_train_pkg::cmd_t        cmdOut,       // Command to device
	output logic [2:0]                 cmdReg,       // Mode register index
	output logic [7:0]                 cmdData,      // Mode register data
	output logic                       qualBit,      // Qualifying data bit
	output logic                       training,     // Training mode active
	output logic                       levelValid,   // Level programmed, settled
	output logic                       retrainNeed,  // Retraining advised
	output logic                       reqIllegal    // Last order refused
);
	typedef enum logic [1:0] {IDLE, ENTRY_WAIT, TRAIN, EXIT_WAIT} state_t;
	state_t                          state_q;      // Sequence state
	logic [ref_train_pkg::CNT_W-1:0] waitCnt_q;    // Delay counter
	logic                            range_q;      // Entry range
	logic [5:0]                      code_q;       // Last programmed code
	logic                            updated_q;    // An update since entry
	logic                            everSet_q;    // Level ever programmed
	logic [1:0]                      driftSync_q;  // Drift synchroniser
	logic                            isData;       // Order is a data command
	logic                            legal;        // Order legal now
	logic                            bigStep;      // Step exceeds short range
	logic [5:0]                      stepSize;     // Magnitude of level change

	// Classify order and check legality
	always_comb begin
		isData   = reqCmd != ref_train_pkg::CMD_MRS;
		stepSize = (reqCode > code_q) ? reqCode - code_q : code_q - reqCode;
		bigStep  = 32'(stepSize) > ref_train_pkg::SHORT_STEP_MAX;
		legal    = 1'b0;
		unique case (state_q)
			IDLE:       legal = !isData ? (reqEnter && banksIdle) : 1'b0;
			ENTRY_WAIT: legal = 1'b0;
			EXIT_WAIT:  legal = 1'b0;
			TRAIN: begin
				if (isData)
					legal = !perDevice && waitCnt_q == '0;
				else if (reqExit)
					legal = banksIdle && updated_q && waitCnt_q == '0;
				else
					legal = !reqEnter && reqCode <= ref_train_pkg::CODE_MAX
						&& waitCnt_q == '0;
			end
		endcase
	end
	assign reqReady = reqValid && legal;

	// Sequence and delay counting
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= IDLE;
			waitCnt_q <= '0;
		end else if (reqReady && !isData && state_q == IDLE) begin
			state_q   <= ENTRY_WAIT;
			waitCnt_q <= ref_train_pkg::CNT_W'(ref_train_pkg::ENTRY_CYC - 1);
		end else if (reqReady && !isData && reqExit) begin
			state_q   <= EXIT_WAIT;
			waitCnt_q <= ref_train_pkg::CNT_W'(ref_train_pkg::EXIT_CYC - 1);
		end else if (reqReady && !isData) begin
			waitCnt_q <= bigStep ? ref_train_pkg::CNT_W'(ref_train_pkg::LONG_CYC - 1)
				: ref_train_pkg::CNT_W'(ref_train_pkg::SHORT_CYC - 1);
		end else if (waitCnt_q != '0) begin
			waitCnt_q <= waitCnt_q - 1'b1;
		end else if (state_q == ENTRY_WAIT) begin
			state_q <= TRAIN;
		end else if (state_q == EXIT_WAIT) begin
			state_q <= IDLE;
		end
	end

	// Remembered range and level
	always_ff @(posedge clk) begin
		if (rst) begin
			range_q   <= ref_train_pkg::SETTING_RST[ref_train_pkg::RANGE_BIT];
			code_q    <= ref_train_pkg::SETTING_RST[5:0];
			updated_q <= 1'b0;
			everSet_q <= 1'b0;
		end else if (reqReady && !isData) begin
			if (state_q == IDLE) begin
				range_q   <= reqRange;
				updated_q <= 1'b0;
			end else if (!reqExit) begin
				code_q    <= reqCode;
				updated_q <= 1'b1;
				everSet_q <= 1'b1;
			end
		end
	end

	// Command slot toward device, registered
	always_ff @(posedge clk) begin
		if (rst) begin
			cmdOut  <= ref_train_pkg::CMD_DES;
			cmdReg  <= 3'h0;
			cmdData <= 8'h00;
			qualBit <= 1'b1;
		end else if (reqReady) begin
			cmdOut  <= reqCmd;
			cmdReg  <= isData ? 3'h0 : ref_train_pkg::TRAIN_REG;
			qualBit <= 1'b0;
			if (isData)
				cmdData <= 8'h00;
			else if (state_q == IDLE)
				cmdData <= {1'b1, reqRange, 6'h00};
			else if (reqExit)
				cmdData <= {1'b0, range_q, code_q};
			else
				cmdData <= {1'b1, range_q, reqCode};
		end else begin
			cmdOut  <= ref_train_pkg::CMD_DES;
			qualBit <= 1'b1;
		end
	end

	// Status outputs and drift synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			training    <= 1'b0;
			levelValid  <= 1'b0;
			retrainNeed <= 1'b0;
			reqIllegal  <= 1'b0;
			driftSync_q <= 2'b00;
		end else begin
			driftSync_q <= {driftSync_q[0], tempDrift};
			training    <= state_q == ENTRY_WAIT || state_q == TRAIN;
			levelValid  <= everSet_q && state_q == IDLE;
			retrainNeed <= driftSync_q[1];
			if (reqValid)
				reqIllegal <= !legal;
		end
	end

	property p_noCmdInEntry;
		@(posedge clk) disable iff (rst)
		state_q == ENTRY_WAIT |-> !reqReady;
	endproperty
	a_noCmdInEntry: assert property (p_noCmdInEntry)
		else $error("Command taken during entry delay");

	property p_desAfterExit;
		@(posedge clk) disable iff (rst)
		// Exit command itself stands one cycle, then deselects follow
		(reqReady && !isData && reqExit && state_q == TRAIN)
			|=> ##1 (cmdOut == ref_train_pkg::CMD_DES) [*8];
	endproperty
	a_desAfterExit: assert property (p_desAfterExit)
		else $error("Non-deselect during exit delay");

	property p_exitIdle;
		@(posedge clk) disable iff (rst)
		(reqReady && !isData && reqExit) |-> banksIdle;
	endproperty
	a_exitIdle: assert property (p_exitIdle)
		else $error("Exit issued with banks open");

	property p_rangeKept;
		@(posedge clk) disable iff (rst)
		(reqReady && !isData && state_q == TRAIN) |=> cmdData[6] == range_q;
	endproperty
	a_rangeKept: assert property (p_rangeKept)
		else $error("Range changed during training");

	property p_codeLegal;
		@(posedge clk) disable iff (rst)
		(reqReady && !isData && state_q == TRAIN && !reqExit)
			|=> cmdData[5:0] <= ref_train_pkg::CODE_MAX;
	endproperty
	a_codeLegal: assert property (p_codeLegal)
		else $error("Reserved level code issued");

	property p_pdaOnlyMrs;
		@(posedge clk) disable iff (rst)
		(reqReady && perDevice && state_q == TRAIN) |-> !isData;
	endproperty
	a_pdaOnlyMrs: assert property (p_pdaOnlyMrs)
		else $error("Data command in per-device mode");

	property p_settle;
		@(posedge clk) disable iff (rst)
		(reqReady && !isData && state_q == TRAIN && !reqExit) |=> !reqReady [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("Command before settling");

	property p_entryEnable;
		@(posedge clk) disable iff (rst)
		(reqReady && state_q == IDLE) |=> cmdData[7] && cmdData[5:0] == 6'h00;
	endproperty
	a_entryEnable: assert property (p_entryEnable)
		else $error("Entry command malformed");

	property p_qualLow;
		@(posedge clk) disable iff (rst)
		reqReady |=> !qualBit;
	endproperty
	a_qualLow: assert property (p_qualLow)
		else $error("Qualifying bit high on issued command");
endmodule : ref_train_ctrl

// ==== verification/ref_train_dev.sv ====
/* Device-side model of the training register: command watch and setting.
   Assumes one command slot per clock from the controller under test. */
`timescale 1ns/1ps
module ref_train_dev (
	input  wire logic                clk,       // Command clock
	input  wire logic                rst,       // Sync reset, high
	input  wire ref_train_pkg::cmd_t cmdOut,    // Command slot
	input  wire logic [2:0]          cmdReg,    // Register index
	input  wire logic [7:0]          cmdData,   // Register data
	input  wire logic                qualBit,   // Qualifying bit
	input  wire logic                perDevice, // Per-device mode
	output logic                     trainQ,    // Training active
	output logic [6:0]               liveQ,     // Range and code
	output logic [6:0]               operQ,     // Setting in use
	output logic                     validQ,    // Setting defined
	output logic                     badQ       // Illegal command
);
	logic mrsHit; // Executed training write
	// Qualifying bit gates writes in per-device mode
	assign mrsHit = cmdOut == ref_train_pkg::CMD_MRS && cmdReg == ref_train_pkg::TRAIN_REG
		&& !(perDevice && qualBit);
	// Register update and legality watch
	always_ff @(posedge clk) begin
		if (rst) begin
			trainQ <= 1'b0;
			validQ <= 1'b0; // No level at power-up
			badQ   <= 1'b0;
			liveQ  <= ref_train_pkg::SETTING_RST;
			operQ  <= ref_train_pkg::SETTING_RST; // Meaningless until validQ
		end else if (mrsHit) begin
			if (!trainQ) begin
				if (cmdData[7]) trainQ <= 1'b1;
				if (cmdData[7]) liveQ[6] <= cmdData[6]; // Code ignored
			end else if (!cmdData[7]) begin
				trainQ <= 1'b0; // Fields kept
				operQ  <= liveQ;
				validQ <= 1'b1;
			end else if (cmdData[5:0] > ref_train_pkg::CODE_MAX || cmdData[6] != liveQ[6]) begin
				badQ <= 1'b1; // Reserved code or range change
			end else begin
				liveQ[5:0] <= cmdData[5:0];
			end
		end else if (cmdOut != ref_train_pkg::CMD_DES && trainQ && perDevice) begin
			badQ <= 1'b1; // Data commands barred
		end
	end
endmodule : ref_train_dev

// ==== verification/ref_train_ctrl_test.sv ====
/* Bench for the training controller: order sequences with expected slots.
   Assumes the device model above and the package timing counts. */
`timescale 1ns/1ps
module ref_train_ctrl_test;
	logic                clk, rst, reqValid, reqReady, reqEnter, reqExit, reqRange;
	logic                banksIdle, perDevice, tempDrift, qualBit, training;
	logic                levelValid, retrainNeed, reqIllegal, trainQ, validQ, badQ;
	ref_train_pkg::cmd_t reqCmd, cmdOut;
	logic [5:0]          reqCode;
	logic [2:0]          cmdReg;
	logic [7:0]          cmdData;
	logic [6:0]          liveQ, operQ;
	int                  miscompares, nChecks, waited;
	ref_train_ctrl u_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
		.reqCmd(reqCmd), .reqEnter(reqEnter), .reqExit(reqExit), .reqRange(reqRange),
		.reqCode(reqCode), .banksIdle(banksIdle), .perDevice(perDevice),
		.tempDrift(tempDrift), .cmdOut(cmdOut), .cmdReg(cmdReg), .cmdData(cmdData),
		.qualBit(qualBit), .training(training), .levelValid(levelValid),
		.retrainNeed(retrainNeed), .reqIllegal(reqIllegal));
	ref_train_dev u_dev (.clk(clk), .rst(rst), .cmdOut(cmdOut), .cmdReg(cmdReg),
		.cmdData(cmdData), .qualBit(qualBit), .perDevice(perDevice), .trainQ(trainQ),
		.liveQ(liveQ), .operQ(operQ), .validQ(validQ), .badQ(badQ));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Verdict and end of run
	task automatic complete_run;
		if (miscompares == 0 && nChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// Compare seen against expected
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// Present one order just after an edge; expect it taken (bounded wait) or refused
	task automatic issue(input ref_train_pkg::cmd_t c, input logic en, input logic ex,
		input logic [5:0] cd, input logic exp);
		reqCmd   = c;
		reqEnter = en;
		reqExit  = ex;
		reqCode  = cd;
		reqValid = 1'b1;
		#1;
		waited = 0;
		while (exp && reqReady !== 1'b1 && waited < 200) begin
			@(posedge clk);
			#2;
			waited++;
		end
		if (waited == 200) miscompares++;
		if (waited == 200) complete_run();
		check(reqReady, exp);
		@(posedge clk);
		#1;
		check(reqIllegal, !exp);
		if (exp) check(8'(cmdOut), 8'(c));
		if (exp) check(qualBit, 1'b0);
		reqValid = 1'b0;
		// One idle edge so the next order never reasserts in the same step
		@(posedge clk);
		#1;
	endtask : issue
	// Main sequence
	initial begin
		{miscompares, nChecks, waited} = '0;
		{rst, reqRange} = 2'b11;
		{reqValid, reqEnter, reqExit, reqCode, banksIdle, perDevice, tempDrift} = '0;
		reqCmd = ref_train_pkg::CMD_DES;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		check(validQ, 1'b0);
		check(levelValid, 1'b0);
		issue(ref_train_pkg::CMD_MRS, 1'b1, 1'b0, 6'h15, 1'b0);
		banksIdle = 1'b1;
		issue(ref_train_pkg::CMD_MRS, 1'b1, 1'b0, 6'h15, 1'b1);
		check(cmdData, 8'hC0);
		check(cmdReg, 8'h06);
		check(trainQ, 1'b1);
		check(8'(liveQ), 8'h40);
		issue(ref_train_pkg::CMD_WR, 1'b0, 1'b0, 6'h00, 1'b0);
		issue(ref_train_pkg::CMD_WR, 1'b0, 1'b0, 6'h00, 1'b1);
		check(training, 1'b1);
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b1, 6'h00, 1'b0);
		for (int k = 1; k < 7; k++) issue(ref_train_pkg::cmd_t'(k), 1'b0, 1'b0, 6'h00, 1'b1);
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b0, 6'h33, 1'b0);
		issue(ref_train_pkg::CMD_MRS, 1'b1, 1'b0, 6'h10, 1'b0);
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b0, 6'h32, 1'b1);
		check(cmdData, 8'hF2);
		check(8'(liveQ), 8'h72);
		issue(ref_train_pkg::CMD_RD, 1'b0, 1'b0, 6'h00, 1'b1);
		check(8'(waited), 8'(ref_train_pkg::LONG_CYC - 2));
		banksIdle = 1'b0;
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b1, 6'h00, 1'b0);
		banksIdle = 1'b1;
		perDevice = 1'b1;
		issue(ref_train_pkg::CMD_WR, 1'b0, 1'b0, 6'h00, 1'b0);
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b0, 6'h30, 1'b1);
		issue(ref_train_pkg::CMD_MRS, 1'b0, 1'b1, 6'h00, 1'b1);
		check(8'(waited), 8'(ref_train_pkg::SHORT_CYC - 2));
		check(cmdData, 8'h70);
		issue(ref_train_pkg::CMD_ACT, 1'b0, 1'b0, 6'h00, 1'b0);
		for (int k = 0; k < 100 && levelValid !== 1'b1; k++) @(posedge clk);
		#1 check(levelValid, 1'b1);
		check(8'(operQ), 8'h70);
		check(badQ, 1'b0);
		tempDrift = 1'b1;
		repeat (5) @(posedge clk);
		#1 check(retrainNeed, 1'b1);
		complete_run();
	end
endmodule : ref_train_ctrl_test
